// ---- inc/charger_regs_params.svh ----
`ifndef CHARGER_REGS_PARAMS_SVH
`define CHARGER_REGS_PARAMS_SVH

`define ADDR_CHARGE_CURRENT 8'h14
`define ADDR_CONDITION_STATUS 8'h20
`define ADDR_PROCHOT_STATUS 8'h21

`define CHARGE_CURRENT_RESET 16'h0000
`define CHARGE_CURRENT_MASK 16'h1FC0
`define CHARGE_CURRENT_RSVD_HI 16'hE000
`define CHARGE_CURRENT_LSB_POS 6
`define CHARGE_CURRENT_STEP_MA 64

`define STAT_INPUT_PRESENT_POS 15
`define STAT_SYSTEM_OVERVOLTAGE_POS 4
`define STAT_LATCHOFF_POS 2
`define PROCHOT_FLAGS_W 7

`endif

// ---- inc/charger_regs_pkg.sv ----
package charger_regs_pkg;

  // host register access as seen after the serial protocol has been decoded
  typedef struct packed {
    logic wrStrobe;
    logic rdStrobe;
    logic rdDone;
    logic [7:0] addr;
    logic [15:0] wrData;
  } host_req_s;

  typedef struct packed {
    logic rdValid;
    logic [15:0] rdData;
  } host_rsp_s;

  // monitored analog and pin conditions
  typedef struct packed {
    logic inputGood;
    logic inputOvervoltage;
    logic systemOvervoltage;
    logic latchOffFault;
    logic batteryPresent;
    logic [6:0] prochotTriggers;
  } charger_events_s;

  typedef enum logic [1:0] {
    RD_IDLE,
    RD_PENDING
  } read_state_e;

endpackage

// ---- rtl/charger_status_and_current_regs.sv ----
`timescale 1ns/1ns
`include "charger_regs_params.svh"

// Notes on behaviour
// - system overvoltage sets status bit 4 and keeps the converter off while set
// - writing zero to bit 4 or unplugging the input clears that latch
// - latch-off fault bit 2 stays set until the host reads the status register
// - processor-hot register shows seven trigger flags in bits 6..0, upper bits zero
// - charge current spans 64 mA to 8.128 A in 64 mA steps
// - current is the sum of bit weights, bit 12 = 4096 mA down to bit 6 = 64 mA
// - writes with any of bits 15..13 set are ignored
// - charge current is zero after power-on reset
// - input-good falling clears charge current unless caused by input overvoltage
// - battery-present pin falling clears charge current
// - current retained through overcurrent, thermal, latch-off and system overvoltage
// - bits 7 and 6 add 128 mA and 64 mA
// - status bit 15 mirrors the input-good pin
module charger_status_and_current_regs
  import charger_regs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire charger_regs_pkg::host_req_s hostReq,
  input wire charger_regs_pkg::charger_events_s events,
  output charger_regs_pkg::host_rsp_s hostRsp,
  output logic [15:0] chargeCurrentSetting,
  output logic [12:0] chargeCurrentMa,
  output logic converterEnable
);
  import charger_regs_pkg::*;

  logic systemOvervoltageFlag;
  logic latchOffFlag;
  logic [6:0] prochotFlags;
  logic inputGoodPrev;
  logic batteryPresentPrev;
  logic inputPresentFlag;
  read_state_e readState;
  // edge detectors start low so no clear fires right after reset
  logic inputGoodFell;
  logic batteryRemoved;
  logic [15:0] next_charge_current_setting;
  logic [15:0] next_readData;
  logic currentWriteValid;
  logic currentClear;
  logic statusReadDone;

  function automatic logic [12:0] current_in_ma(input logic [15:0] value);
    logic [12:0] ma;
    ma = 13'(value[12:6]) * 13'(`CHARGE_CURRENT_STEP_MA);
    return ma;
  endfunction

  // is_write and is_read decode every strobed address test; the read-data mux matches hostReq.addr with its own case
  function automatic logic is_write(input charger_regs_pkg::host_req_s req,
                                    input logic [7:0] target);
    logic hit;
    hit = req.wrStrobe && (req.addr == target);
    return hit;
  endfunction

  function automatic logic is_read(input charger_regs_pkg::host_req_s req,
                                   input logic [7:0] target);
    logic hit;
    hit = req.rdStrobe && (req.addr == target);
    return hit;
  endfunction

  function automatic logic [15:0] status_word(input logic present, input logic ovp,
                                              input logic latchOff);
    logic [15:0] word;
    word = 16'h0000;
    word[`STAT_INPUT_PRESENT_POS] = present;
    word[`STAT_SYSTEM_OVERVOLTAGE_POS] = ovp;
    word[`STAT_LATCHOFF_POS] = latchOff;
    return word;
  endfunction

  assign inputGoodFell = inputGoodPrev && !events.inputGood;
  assign batteryRemoved = batteryPresentPrev && !events.batteryPresent;
  // reserved bits high mark the whole word invalid, not just those bits
  assign currentWriteValid = is_write(hostReq, `ADDR_CHARGE_CURRENT)
                             && (hostReq.wrData & `CHARGE_CURRENT_RSVD_HI) == 16'h0000;
  // an input overvoltage also drops input-good but must leave the setting alone
  assign currentClear = (inputGoodFell && !events.inputOvervoltage) || batteryRemoved;
  assign statusReadDone = (readState == RD_PENDING) && hostReq.rdDone;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      inputGoodPrev <= 1'b0;
      batteryPresentPrev <= 1'b0;
    end
    else
    begin
      inputGoodPrev <= events.inputGood;
      batteryPresentPrev <= events.batteryPresent;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      inputPresentFlag <= 1'b0;
    end
    else
    begin
      inputPresentFlag <= events.inputGood;
    end
  end

  // overcurrent, thermal, latch-off and system overvoltage inputs never reach this path
  always_comb
  begin
    next_charge_current_setting = chargeCurrentSetting;
    if (currentWriteValid)
    begin
      next_charge_current_setting = hostReq.wrData & `CHARGE_CURRENT_MASK;
    end
    if (currentClear)
    begin
      next_charge_current_setting = `CHARGE_CURRENT_RESET;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      chargeCurrentSetting <= `CHARGE_CURRENT_RESET;
    end
    else
    begin
      chargeCurrentSetting <= next_charge_current_setting;
    end
  end

  // the mA value is taken from the next word so it never lags the register
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      chargeCurrentMa <= 13'h0000;
    end
    else
    begin
      chargeCurrentMa <= current_in_ma(next_charge_current_setting);
    end
  end

  // the event is tested last so a new overvoltage beats a host clear
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      systemOvervoltageFlag <= 1'b0;
    end
    else
    begin
      if (is_write(hostReq, `ADDR_CONDITION_STATUS)
          && !hostReq.wrData[`STAT_SYSTEM_OVERVOLTAGE_POS])
      begin
        systemOvervoltageFlag <= 1'b0;
      end
      // unplugging the adapter is the other way out of the latch
      if (inputGoodFell)
      begin
        systemOvervoltageFlag <= 1'b0;
      end
      if (events.systemOvervoltage)
      begin
        systemOvervoltageFlag <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      converterEnable <= 1'b0;
    end
    else
    begin
      // the live input also gates, so the first overvoltage cycle already stops it
      converterEnable <= !systemOvervoltageFlag && !events.systemOvervoltage;
    end
  end

  // read handshake: clear-on-read waits for rdDone, so a fault stays only if it is still asserted in the rdDone cycle
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      readState <= RD_IDLE;
    end
    else
    begin
      case (readState)
        RD_IDLE:
        begin
          // a read of another register never opens a clear window
          if (is_read(hostReq, `ADDR_CONDITION_STATUS))
          begin
            readState <= RD_PENDING;
          end
        end
        RD_PENDING:
        begin
          if (hostReq.rdDone)
          begin
            readState <= RD_IDLE;
          end
        end
        default:
        begin
          readState <= RD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      latchOffFlag <= 1'b0;
    end
    else
    begin
      if (statusReadDone)
      begin
        latchOffFlag <= 1'b0;
      end
      if (events.latchOffFault)
      begin
        latchOffFlag <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prochotFlags <= 7'h00;
    end
    else
    begin
      // live copy, not sticky: the trigger side owns how long a flag stays
      prochotFlags <= events.prochotTriggers;
    end
  end

  // unmapped addresses read zero so a probing host never sees a stale word
  always_comb
  begin
    next_readData = 16'h0000;
    case (hostReq.addr)
      `ADDR_CHARGE_CURRENT:
      begin
        next_readData = chargeCurrentSetting;
      end
      `ADDR_CONDITION_STATUS:
      begin
        next_readData = status_word(inputPresentFlag, systemOvervoltageFlag, latchOffFlag);
      end
      `ADDR_PROCHOT_STATUS:
      begin
        next_readData = {9'h000, prochotFlags};
      end
      default:
      begin
        next_readData = 16'h0000;
      end
    endcase
  end

  // read data is captured at the strobe and held until the next read
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hostRsp <= '0;
    end
    else
    begin
      hostRsp.rdValid <= hostReq.rdStrobe;
      if (hostReq.rdStrobe)
      begin
        hostRsp.rdData <= next_readData;
      end
    end
  end

endmodule

// ---- test/charger_regs_monitor.sv ----
`timescale 1ns/1ns
module charger_regs_monitor
  import charger_regs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire charger_regs_pkg::host_req_s hostReq,
  input wire charger_regs_pkg::charger_events_s events,
  input wire charger_regs_pkg::host_rsp_s hostRsp,
  input wire logic [15:0] chargeCurrentSetting,
  input wire logic [12:0] chargeCurrentMa,
  input wire logic converterEnable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire wr14 = hostReq.wrStrobe && hostReq.addr == 8'h14;
  a_ovp_conv_off: assert property (events.systemOvervoltage |-> ##2 !converterEnable)
    else $error("converter on");
  a_wr_applied: assert property (wr14 && hostReq.wrData[15:13] == 3'h0
    |=> chargeCurrentSetting == ($past(hostReq.wrData) & 16'h1FC0)) else $error("write");
  a_bad_wr_held: assert property (wr14 && |hostReq.wrData[15:13]
    |=> $stable(chargeCurrentSetting)) else $error("bad write");
  a_ma_weights: assert property (chargeCurrentMa == {chargeCurrentSetting[12:6], 6'h00})
    else $error("mA");
  a_batt_clear: assert property ($fell(events.batteryPresent)
    |-> ##[1:2] chargeCurrentSetting == 16'h0000) else $error("removal");
  a_input_clear: assert property ($fell(events.inputGood) && !events.inputOvervoltage
    |-> ##[1:2] chargeCurrentSetting == 16'h0000) else $error("input loss");
  a_ovin_keep: assert property ($fell(events.inputGood) && events.inputOvervoltage
    && !hostReq.wrStrobe |=> $stable(chargeCurrentSetting)) else $error("input ov");
  a_rsvd_zero: assert property (hostReq.rdStrobe && hostReq.addr == 8'h21
    |=> hostRsp.rdData[15:7] == 9'h000) else $error("reserved");
endmodule

// ---- test/host_model.sv ----
`timescale 1ns/1ns
module host_model
  import charger_regs_pkg::*;
(
  input wire logic sys_clk,
  input wire charger_regs_pkg::host_rsp_s rsp,
  output charger_regs_pkg::host_req_s req
);
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    req = '{1'b1, 1'b0, 1'b0, a, d};
    @(negedge sys_clk);
    req.wrStrobe = 1'b0;
    req.wrData = ~d;
  endtask
  // a missing answer returns unknown data, so the caller's compare fails
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge sys_clk);
    req.addr = a;
    req.rdStrobe = 1'b1;
    @(negedge sys_clk);
    req.rdStrobe = 1'b0;
    d = rsp.rdValid === 1'b1 ? rsp.rdData : 16'hXXXX;
    req.rdDone = rsp.rdValid === 1'b1 && a == 8'h20;
    @(negedge sys_clk);
    req.rdDone = 1'b0;
  endtask
endmodule

// ---- test/charger_status_and_current_regs_tb_top.sv ----
`timescale 1ns/1ns
module charger_status_and_current_regs_tb_top;
  import charger_regs_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  host_req_s hostReq;
  host_rsp_s hostRsp;
  charger_events_s events = 12'h880;
  logic [15:0] chargeCurrentSetting;
  logic [15:0] rdv;
  logic [12:0] chargeCurrentMa;
  logic converterEnable;
  int errCount = 0;
  int comparisons = 0;
  always #2 sys_clk = ~sys_clk;
  charger_status_and_current_regs u_charger_status_and_current_regs (.sys_clk, .arst_n,
    .hostReq, .events, .hostRsp, .chargeCurrentSetting, .chargeCurrentMa, .converterEnable);
  host_model u_host_model (.sys_clk, .rsp(hostRsp), .req(hostReq));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude();
    $display("errors %0d comparisons %0d", errCount, comparisons);
    if (errCount == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    u_host_model.rd(a, rdv);
    chk("read", e, rdv);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  initial
  begin
    tick(3);
    arst_n = 1'b1;
    tick(2);
    chk("enable", 16'h0001, {15'h0, converterEnable});
    rd(8'h14, 16'h0000);
    u_host_model.wr(8'h14, 16'h1FC0);
    chk("mA", 16'h1FC0, {3'h0, chargeCurrentMa});
    u_host_model.wr(8'h14, 16'hE040);
    chk("current", 16'h1FC0, chargeCurrentSetting);
    u_host_model.wr(8'h14, 16'h0040);
    chk("mA", 16'h0040, {3'h0, chargeCurrentMa});
    for (int i = 0; i < 7; i++)
    begin
      events.prochotTriggers = 7'(1 << i);
      tick(2);
      rd(8'h21, 16'(1 << i));
    end
    events.latchOffFault = 1'b1;
    tick(1);
    events.latchOffFault = 1'b0;
    tick(2);
    rd(8'h20, 16'h8004);
    rd(8'h20, 16'h8000);
    events.latchOffFault = 1'b1;
    rd(8'h20, 16'h8004);
    events.latchOffFault = 1'b0;
    rd(8'h20, 16'h8004);
    rd(8'h20, 16'h8000);
    events.systemOvervoltage = 1'b1;
    tick(3);
    events.systemOvervoltage = 1'b0;
    tick(3);
    chk("enable", 16'h0000, {15'h0, converterEnable});
    rd(8'h20, 16'h8010);
    u_host_model.wr(8'h20, 16'h0000);
    tick(2);
    chk("enable", 16'h0001, {15'h0, converterEnable});
    events = 12'h480;
    tick(2);
    chk("current", 16'h0040, chargeCurrentSetting);
    events = 12'h800;
    tick(2);
    chk("current", 16'h0000, chargeCurrentSetting);
    events.batteryPresent = 1'b1;
    u_host_model.wr(8'h14, 16'h0FC0);
    events.inputGood = 1'b0;
    tick(2);
    chk("current", 16'h0000, chargeCurrentSetting);
    rd(8'h20, 16'h0000);
    conclude();
  end
endmodule
bind charger_status_and_current_regs charger_regs_monitor u_mon (.sys_clk, .arst_n,
  .hostReq, .events, .hostRsp, .chargeCurrentSetting, .chargeCurrentMa, .converterEnable);
